// ### pmw_power_ctrl.sv
// Power management control: readiness, suspend state, transceiver reset, wake
// Assumes one 25 MHz clock, synchronous inputs and a single-cycle strobe bus
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "pmw_consts.svh"

// Overview of operation
// (RULE1) Ready flag is read-only, zero at reset, low until the transceiver runs.
// (RULE2) Ready flag stays low while configuration memory is still loading.
// (RULE3) Suspend state select at bits 6:5, default 10b, chooses low-power state.
// (RULE4) Becoming unconfigured returns suspend state select to 10b.
// (RULE5) Software keeps state two selected while the device is unconfigured.
// (RULE6) Low-power states zero and one behave the same.
// (RULE7) Writing one to bit 4 resets the transceiver for at least 4 ms.
// (RULE8) Bit 4 clears itself when the transceiver leaves reset.
// (RULE9) Writes to bit 4 are ignored while it reads high.
// (RULE10) Setting bit 4 clears ready; ready returns once the transceiver runs.
// (RULE11) Reset hold lengthens to 128 ms unless reference settle wait is skipped.
// (RULE12) Software should set bit 4 after resuming from state two.
// (RULE13) Bit 3 enables wake-on-LAN events as wake sources, default 0.
// (RULE14) Bit 2 enables the transceiver interrupt as a wake source, default 0.
// (RULE15) Remote resume completion clears both wake enables when so configured.
// (RULE16) Wake cause at bits 1:0, default 00b, cleared by writing one.
// (RULE17) Bit 0 marks transceiver wake, bit 1 marks LAN frame wakes.
// (RULE18) Energy-efficient cause: receive wake in states 0 and 3, transmit in 3.
// (RULE19) Several causes may set together, each only if valid in current state.
// (RULE20) Wake causes set regardless of the two wake enables.
// (RULE21) Remote resume completion clears cause bit 1 when so configured.
// (RULE22) Software never clears causes and changes suspend select in one write.
// (RULE23) Skipping settle wait keeps the reference on during transceiver reset.
// (RULE24) Only remote-wake resumes clear enables and status; host resumes do not.
// (RULE25) Wake causes hold until cleared by software or a qualifying resume.
module pmw_power_ctrl
  import pmw_pkg::*;
#(
  parameter int unsigned HOLD_MIN_CYC = `PMW_HOLD_MIN_MS * `PMW_CLK_KHZ,
  parameter int unsigned HOLD_EXT_CYC = `PMW_HOLD_EXT_MS * `PMW_CLK_KHZ
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire pmw_bus_s    bus,
  output logic [31:0]      reg_rdata,
  // Device state
  input  wire pmw_sys_s    sys,
  // Wake events
  input  wire pmw_wake_s   wake_ev,
  // Transceiver control
  output logic             xcvr_reset,
  output logic             xcvr_ref_enable,
  // Power state outputs
  output logic             ready,
  output logic [1:0]       suspend_state,
  output logic             remote_wake
);

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic hit_ctrl(input logic [`PMW_ADDR_W-1:0] a);
    hit_ctrl = (a == `PMW_CTRL_OFFSET);
  endfunction : hit_ctrl

  // States zero and one share one behaviour
  function automatic logic [1:0] norm_state(input logic [1:0] m);
    norm_state = (m == `PMW_LPS1) ? `PMW_LPS0 : m; // RULE6
  endfunction : norm_state

  // ****************************************
  // Declarations
  // ****************************************
  logic                   ctrl_wr;
  logic                   ctrl_rd;
  logic [31:0]            wd;
  logic [1:0]             mode_r;
  logic                   xrst_r;
  logic                   lan_en_r;
  logic                   xint_en_r;
  logic                   clr_en_r;
  logic                   clr_sts_r;
  logic                   skip_wait_r;
  logic                   ready_r;
  logic                   ready_nxt;
  logic                   configured_r;
  logic                   arm_r;
  logic                   remote_wake_r;
  logic [31:0]            rdata_r;
  logic [31:0]            ctrl_word;
  pmw_xr_e                xr_state_r;
  pmw_xr_e                xr_state_nxt;
  logic                   start_sw;
  logic                   hw_hold;
  logic                   timer_load;
  logic                   timer_busy;
  logic                   timer_done;
  logic [`PMW_CNT_W-1:0]  hold_len;
  logic                   remote_resume;
  logic [1:0]             eff_state;
  logic [2:0]             cause_set;
  logic [2:0]             cause_clr;
  logic [2:0]             cause_r;

  // ****************************************
  // Register port decode
  // ****************************************
  assign ctrl_wr = bus.wr && hit_ctrl(bus.addr);
  assign ctrl_rd = bus.rd && hit_ctrl(bus.addr);
  assign wd      = bus.wdata;

  assign remote_resume = sys.resume_done && sys.resume_remote; // RULE24
  assign eff_state     = norm_state(mode_r);

  // ****************************************
  // Configuration tracking
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      configured_r <= 1'b0;
    end else begin
      configured_r <= sys.configured;
    end
  end

  // ****************************************
  // Suspend state select
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_r <= `PMW_MODE_RST; // RULE3
    end else if (configured_r && !sys.configured) begin
      mode_r <= `PMW_MODE_RST; // RULE4
    end else if (ctrl_wr) begin
      mode_r <= wd[`PMW_B_MODE_HI:`PMW_B_MODE_LO]; // RULE3
    end
  end

  assign suspend_state = mode_r;

  // ****************************************
  // Wake enables
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      lan_en_r  <= 1'b0;
      xint_en_r <= 1'b0;
    end else if (remote_resume && clr_en_r) begin
      lan_en_r  <= 1'b0; // RULE15
      xint_en_r <= 1'b0; // RULE15
    end else if (ctrl_wr) begin
      lan_en_r  <= wd[`PMW_B_LAN_EN];  // RULE13
      xint_en_r <= wd[`PMW_B_XINT_EN]; // RULE14
    end
  end

  // ****************************************
  // Resume and reference options
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      clr_en_r    <= `PMW_CLR_EN_RST;
      clr_sts_r   <= `PMW_CLR_STS_RST;
      skip_wait_r <= `PMW_SKIP_RST;
    end else if (ctrl_wr) begin
      clr_en_r    <= wd[`PMW_B_CLR_EN];
      clr_sts_r   <= wd[`PMW_B_CLR_STS];
      skip_wait_r <= wd[`PMW_B_SKIP_WAIT];
    end
  end

  // ****************************************
  // Transceiver reset request bit
  // ****************************************
  assign start_sw = ctrl_wr && wd[`PMW_B_XRST] && !xrst_r; // RULE9
  assign hw_hold  = !sys.configured || (sys.suspended && (mode_r == `PMW_LPS2));

  always_ff @(posedge clock) begin
    if (rst) begin
      xrst_r <= 1'b0;
    end else if (start_sw) begin
      xrst_r <= 1'b1; // RULE7
    end else if ((xr_state_r == XR_HOLD) && timer_done && !timer_load) begin
      xrst_r <= 1'b0; // RULE8
    end
  end

  // ****************************************
  // Reset hold timer
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      arm_r <= 1'b1;
    end else begin
      arm_r <= 1'b0;
    end
  end

  assign hold_len = (ctrl_wr ? wd[`PMW_B_SKIP_WAIT] : skip_wait_r) ? `PMW_CNT_W'(HOLD_MIN_CYC)
                                                                   : `PMW_CNT_W'(HOLD_EXT_CYC); // RULE11
  assign timer_load = arm_r || start_sw || hw_hold; // RULE7

  pmw_hold_timer u_hold_timer (
    .clock  (clock),
    .rst    (rst),
    .load   (timer_load),
    .length (hold_len),
    .busy   (timer_busy),
    .done_r (timer_done)
  );

  // ****************************************
  // Transceiver reset sequence
  // ****************************************
  always_comb begin
    xr_state_nxt = xr_state_r;
    case (xr_state_r)
      XR_HOLD: begin
        if (timer_done && !timer_load && !timer_busy) begin
          xr_state_nxt = XR_SETTLE; // RULE8
        end
      end
      XR_SETTLE: begin
        if (start_sw || hw_hold) begin
          xr_state_nxt = XR_HOLD;
        end else if (sys.xcvr_up) begin
          xr_state_nxt = XR_RUN; // RULE1
        end
      end
      XR_RUN: begin
        if (start_sw || hw_hold) begin
          xr_state_nxt = XR_HOLD; // RULE7
        end
      end
      default: begin
        xr_state_nxt = XR_HOLD;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      xr_state_r <= XR_HOLD;
    end else begin
      xr_state_r <= xr_state_nxt;
    end
  end

  assign xcvr_reset      = (xr_state_r == XR_HOLD); // RULE7
  assign xcvr_ref_enable = !xcvr_reset || skip_wait_r; // RULE23

  // ****************************************
  // Readiness
  // ****************************************
  assign ready_nxt = (xr_state_r == XR_RUN) // RULE1
                  && !sys.load_busy         // RULE2
                  && !start_sw;             // RULE10

  always_ff @(posedge clock) begin
    if (rst) begin
      ready_r <= 1'b0; // RULE1
    end else begin
      ready_r <= ready_nxt; // RULE10
    end
  end

  assign ready = ready_r;

  // ****************************************
  // Wake cause capture
  // ****************************************
  always_comb begin
    cause_set    = 3'h0;
    cause_set[0] = sys.suspended && wake_ev.xcvr; // RULE17 RULE20
    cause_set[1] = sys.suspended && wake_ev.lan;  // RULE17 RULE20
    cause_set[2] = sys.suspended
                && ((wake_ev.eee_rx && (eff_state != `PMW_LPS2))
                 || (wake_ev.eee_tx && (eff_state == `PMW_LPS3))); // RULE18 RULE19
  end

  always_comb begin
    cause_clr    = 3'h0;
    cause_clr[0] = ctrl_wr && wd[`PMW_B_CAUSE_LO]; // RULE16
    cause_clr[1] = (ctrl_wr && wd[`PMW_B_CAUSE_HI])
                || (remote_resume && clr_sts_r); // RULE21
    cause_clr[2] = (ctrl_wr && wd[`PMW_B_EEE_CAUSE])
                || (remote_resume && clr_sts_r);
  end

  generate
    for (genvar i = 0; i < 3; i++) begin : g_cause
      pmw_sticky_flag u_cause (
        .clock  (clock),
        .rst    (rst),
        .set    (cause_set[i]),
        .clr    (cause_clr[i]),
        .flag_r (cause_r[i])
      ); // RULE25
    end
  endgenerate

  // ****************************************
  // Remote wake request
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      remote_wake_r <= 1'b0;
    end else begin
      remote_wake_r <= sys.suspended
                    && ((lan_en_r && wake_ev.lan)      // RULE13
                     || (xint_en_r && wake_ev.xcvr));  // RULE14
    end
  end

  assign remote_wake = remote_wake_r;

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    ctrl_word                                 = 32'h0;
    ctrl_word[`PMW_B_SKIP_WAIT]               = skip_wait_r;
    ctrl_word[`PMW_B_EEE_CAUSE]               = cause_r[2];
    ctrl_word[`PMW_B_CLR_STS]                 = clr_sts_r;
    ctrl_word[`PMW_B_CLR_EN]                  = clr_en_r;
    ctrl_word[`PMW_B_READY]                   = ready_r;
    ctrl_word[`PMW_B_MODE_HI:`PMW_B_MODE_LO]  = mode_r;
    ctrl_word[`PMW_B_XRST]                    = xrst_r;
    ctrl_word[`PMW_B_LAN_EN]                  = lan_en_r;
    ctrl_word[`PMW_B_XINT_EN]                 = xint_en_r;
    ctrl_word[`PMW_B_CAUSE_HI:`PMW_B_CAUSE_LO] = cause_r[1:0];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= 32'h0;
    end else if (ctrl_rd) begin
      rdata_r <= ctrl_word;
    end else begin
      rdata_r <= 32'h0;
    end
  end

  assign reg_rdata = rdata_r;

endmodule : pmw_power_ctrl
`default_nettype wire

// ### pmw_consts.svh
// Constants for the power management and wake control block
// Assumes inclusion by bare name from the package and the design modules
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define PMW_ADDR_W        8
`define PMW_CTRL_OFFSET   8'h00

// ****************************************
// Field positions
// ****************************************
`define PMW_B_SKIP_WAIT   15
`define PMW_B_EEE_CAUSE   12
`define PMW_B_CLR_STS     9
`define PMW_B_CLR_EN      8
`define PMW_B_READY       7
`define PMW_B_MODE_HI     6
`define PMW_B_MODE_LO     5
`define PMW_B_XRST        4
`define PMW_B_LAN_EN      3
`define PMW_B_XINT_EN     2
`define PMW_B_CAUSE_HI    1
`define PMW_B_CAUSE_LO    0

// ****************************************
// Reset values and encodings
// ****************************************
`define PMW_MODE_RST      2'h2
`define PMW_CLR_EN_RST    1'h1
`define PMW_CLR_STS_RST   1'h0
`define PMW_SKIP_RST      1'h0
`define PMW_LPS0          2'h0
`define PMW_LPS1          2'h1
`define PMW_LPS2          2'h2
`define PMW_LPS3          2'h3

// ****************************************
// Timing
// ****************************************
`define PMW_CLK_KHZ       25000
`define PMW_HOLD_MIN_MS   4
`define PMW_HOLD_EXT_MS   128
`define PMW_CNT_W         22

`endif

// ### pmw_pkg.sv
// Types for the power management and wake control block
// Assumes pmw_consts.svh is on the include path
`include "pmw_consts.svh"

package pmw_pkg;

  // ****************************************
  // Transceiver reset sequence states
  // ****************************************
  typedef enum logic [1:0] {
    XR_HOLD,
    XR_SETTLE,
    XR_RUN
  } pmw_xr_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [`PMW_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
  } pmw_bus_s;

  typedef struct packed {
    logic xcvr;
    logic lan;
    logic eee_rx;
    logic eee_tx;
  } pmw_wake_s;

  typedef struct packed {
    logic load_busy;
    logic configured;
    logic suspended;
    logic resume_done;
    logic resume_remote;
    logic xcvr_up;
  } pmw_sys_s;

endpackage : pmw_pkg

// ### pmw_hold_timer.sv
// Down counter that times the transceiver reset hold
// Assumes a single clock and synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
`include "pmw_consts.svh"

module pmw_hold_timer (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Control
  input  wire logic                  load,
  input  wire logic [`PMW_CNT_W-1:0] length,
  // Status
  output logic                       busy,
  output logic                       done_r
);

  logic [`PMW_CNT_W-1:0] cnt_r;

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= length;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - `PMW_CNT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == `PMW_CNT_W'(1)) && !load;
    end
  end

  assign busy = (cnt_r != '0);

endmodule : pmw_hold_timer
`default_nettype wire

// ### pmw_sticky_flag.sv
// Sticky status bit, set by hardware, cleared by software or resume
// Assumes a single clock and synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module pmw_sticky_flag (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Events
  input  wire logic set,
  input  wire logic clr,
  // State
  output logic      flag_r
);

  // ****************************************
  // Flag, set wins over clear
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clr) begin
      flag_r <= 1'b0;
    end
  end

endmodule : pmw_sticky_flag
`default_nettype wire

// ### pmw_power_ctrl_assertions.sv
// Concurrent checks on the power management control block ports
// Assumes binding onto pmw_power_ctrl, one clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
`include "pmw_consts.svh"

module pmw_power_ctrl_assertions
  import pmw_pkg::*;
#(
  parameter int unsigned HOLD_MIN_CYC = 20,
  parameter int unsigned HOLD_EXT_CYC = 50
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Watched ports
  input wire pmw_bus_s    bus,
  input wire logic [31:0] reg_rdata,
  input wire pmw_sys_s    sys,
  input wire pmw_wake_s   wake_ev,
  input wire logic        xcvr_reset,
  input wire logic        xcvr_ref_enable,
  input wire logic        ready,
  input wire logic [1:0]  suspend_state,
  input wire logic        remote_wake
);
  int hi_cnt_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ****************************************
  // Helper: cycles transceiver reset stood high
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst || !xcvr_reset) begin
      hi_cnt_r <= 0;
    end else begin
      hi_cnt_r <= hi_cnt_r + 1;
    end
  end

  sequence s_xrst_req;
    bus.wr && bus.addr == `PMW_CTRL_OFFSET && bus.wdata[`PMW_B_XRST] && !xcvr_reset;
  endsequence

  sequence s_hold_end;
    $fell(xcvr_reset);
  endsequence

  chk_xrst_start: assert property (s_xrst_req |=> xcvr_reset && !ready)
    else $error("transceiver reset request not taken");
  chk_hold_min: assert property (s_hold_end |-> hi_cnt_r >= HOLD_MIN_CYC)
    else $error("transceiver reset hold too short");
  chk_hold_ext: assert property ($fell(xcvr_reset) && !$past(xcvr_ref_enable) |-> hi_cnt_r >= HOLD_EXT_CYC)
    else $error("extended transceiver reset hold too short");
  chk_ref_on_run: assert property (!xcvr_reset |-> xcvr_ref_enable)
    else $error("reference off outside transceiver reset");
  chk_ready_in_reset: assert property (xcvr_reset [*2] |-> !ready)
    else $error("ready high during transceiver reset");
  chk_ready_load: assert property (sys.load_busy [*2] |-> !ready)
    else $error("ready high while configuration loads");
  chk_ready_rise: assert property ($rose(ready) |-> $past(sys.xcvr_up, 2) && !$past(sys.load_busy))
    else $error("ready rose without operational transceiver");
  chk_mode_unconf: assert property ($fell(sys.configured) |=> suspend_state == `PMW_LPS2)
    else $error("suspend select not restored on unconfigure");
  chk_mode_write: assert property (bus.wr && bus.addr == `PMW_CTRL_OFFSET && sys.configured
    |=> suspend_state == $past(bus.wdata[6:5]))
    else $error("suspend select write not taken");
  chk_read_fields: assert property ($past(bus.rd && bus.addr == `PMW_CTRL_OFFSET)
    |-> reg_rdata[7:5] == {$past(ready), $past(suspend_state)})
    else $error("read data disagrees with ready or suspend select");
  chk_rdata_idle: assert property (!$past(bus.rd && bus.addr == `PMW_CTRL_OFFSET) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  chk_wake_cause: assert property (remote_wake |-> $past(sys.suspended && (wake_ev.lan || wake_ev.xcvr)))
    else $error("remote wake without suspended event");
endmodule : pmw_power_ctrl_assertions

bind pmw_power_ctrl pmw_power_ctrl_assertions #(
  .HOLD_MIN_CYC(HOLD_MIN_CYC),
  .HOLD_EXT_CYC(HOLD_EXT_CYC)
) chk_inst (
  .clock(clock), .rst(rst), .bus(bus), .reg_rdata(reg_rdata), .sys(sys), .wake_ev(wake_ev),
  .xcvr_reset(xcvr_reset), .xcvr_ref_enable(xcvr_ref_enable), .ready(ready),
  .suspend_state(suspend_state), .remote_wake(remote_wake)
);

`default_nettype wire

// ### pmw_xcvr_model.sv
// Behavioural transceiver that reports operational some cycles after reset release
// Assumes the same clock and synchronous reset as the control block
`timescale 1ns/10ps
`default_nettype none

module pmw_xcvr_model #(
  parameter int UP_DLY = 3
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Transceiver side
  input  wire logic xcvr_reset,
  output logic      xcvr_up
);
  int cnt_r;

  // ****************************************
  // Start-up delay after reset release
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst || xcvr_reset) begin
      cnt_r   <= 0;
      xcvr_up <= 1'b0;
    end else if (cnt_r < UP_DLY) begin
      cnt_r <= cnt_r + 1;
    end else begin
      xcvr_up <= 1'b1;
    end
  end
endmodule : pmw_xcvr_model

`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the power management control block
// Assumes design, checker and transceiver model are compiled before it
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h expected %h", $time, a, e); end end

module testbench
  import pmw_pkg::*;
();
  localparam int MIN_C = 20;
  localparam int EXT_C = 50;
  logic        clock;
  logic        rst;
  pmw_bus_s    bus;
  pmw_wake_s   wake_ev;
  pmw_sys_s    sys_v;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic [1:0]  suspend_state;
  logic        load_busy, configured, suspended, resume_done, resume_remote;
  logic        xcvr_up, xcvr_reset, xcvr_ref_enable, ready, remote_wake;
  int          num_errors;
  int          check_count;

  assign sys_v = {load_busy, configured, suspended, resume_done, resume_remote, xcvr_up};

  pmw_power_ctrl #(.HOLD_MIN_CYC(MIN_C), .HOLD_EXT_CYC(EXT_C)) pmw_power_ctrl_inst (
    .clock(clock), .rst(rst), .bus(bus), .reg_rdata(reg_rdata), .sys(sys_v), .wake_ev(wake_ev),
    .xcvr_reset(xcvr_reset), .xcvr_ref_enable(xcvr_ref_enable), .ready(ready),
    .suspend_state(suspend_state), .remote_wake(remote_wake));
  pmw_xcvr_model #(.UP_DLY(3)) pmw_xcvr_model_inst (
    .clock(clock), .rst(rst), .xcvr_reset(xcvr_reset), .xcvr_up(xcvr_up));

  // ****************************************
  // Bus and stimulus tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clock);
    bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic pulse(input pmw_wake_s w);
    @(posedge clock);
    wake_ev <= w;
    @(posedge clock);
    wake_ev <= '0;
  endtask : pulse

  task automatic resume(input logic r);
    @(posedge clock);
    resume_done   <= 1'b1;
    resume_remote <= r;
    @(posedge clock);
    resume_done <= 1'b0;
  endtask : resume

  task automatic wait_ready();
    int i;
    i = 0;
    while (ready !== 1'b1 && i < 400) begin
      @(posedge clock);
      #1;
      i++;
    end
    #1;
    `CHK(ready, 1'b1)
  endtask : wait_ready

  task automatic results();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_up();
    rd(8'h00, d);
    `CHK(d & 32'hffff_ffef, 32'h0000_0140)
    wait_ready();
    @(posedge clock);
    load_busy <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    `CHK(ready, 1'b0)
    @(posedge clock);
    load_busy <= 1'b0;
    wait_ready();
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_xrst(input logic sk);
    int n;
    int l;
    logic [31:0] w;
    w = {16'h0, sk, 15'h0150};
    l = sk ? MIN_C : EXT_C;
    wr(8'h00, w);
    #1;
    `CHK(xcvr_reset, 1'b1)
    `CHK(ready, 1'b0)
    `CHK(xcvr_ref_enable, sk)
    rd(8'h00, d);
    `CHK(d[4], 1'b1)
    wr(8'h00, w);
    #1;
    n = 5;
    while (xcvr_reset === 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK(n >= l + 1 && n <= l + 4, 1'b1)
    rd(8'h00, d);
    `CHK(d[4], 1'b0)
    wait_ready();
    $display("test transceiver_reset done");
  endtask : t_xrst

  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'h100 | (m << 5));
      rd(8'h00, d);
      `CHK(d[6:5], m[1:0])
    end
    wr(8'h04, 32'h0000_0140);
    rd(8'h04, d);
    `CHK(d, 32'h0)
    `CHK(suspend_state, 2'h3)
    @(posedge clock);
    configured <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK(suspend_state, 2'h2)
    `CHK(ready, 1'b0)
    @(posedge clock);
    configured <= 1'b1;
    wait_ready();
    $display("test suspend_select done");
  endtask : t_modes

  task automatic t_wake();
    wr(8'h00, 32'h0000_0340);
    suspended <= 1'b1;
    pulse(4'b1011);
    #1;
    `CHK(remote_wake, 1'b0)
    rd(8'h00, d);
    `CHK(d & 32'h0000_1003, 32'h0000_0001)
    wr(8'h00, 32'h0000_036c);
    pulse(4'b0100);
    #1;
    `CHK(remote_wake, 1'b1)
    pulse(4'b1000);
    #1;
    `CHK(remote_wake, 1'b1)
    pulse(4'b0001);
    repeat (4) @(posedge clock);
    rd(8'h00, d);
    `CHK(d & 32'h0000_100f, 32'h0000_100f)
    wr(8'h00, 32'h0000_036d);
    rd(8'h00, d);
    `CHK(d & 32'h0000_100f, 32'h0000_100e)
    @(posedge clock);
    suspended <= 1'b0;
    resume(1'b0);
    rd(8'h00, d);
    `CHK(d & 32'h0000_100f, 32'h0000_100e)
    resume(1'b1);
    rd(8'h00, d);
    `CHK(d & 32'h0000_100f, 32'h0000_0000)
    wr(8'h00, 32'h0000_0120);
    suspended <= 1'b1;
    pulse(4'b0010);
    rd(8'h00, d);
    `CHK(d & 32'h0000_100f, 32'h0000_1000)
    @(posedge clock);
    suspended <= 1'b0;
    $display("test wake_cause done");
  endtask : t_wake

  // ****************************************
  // Clock, main sequence and watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    rst           = 1'b1;
    bus           = '0;
    wake_ev       = '0;
    load_busy     = 1'b0;
    configured    = 1'b1;
    suspended     = 1'b0;
    resume_done   = 1'b0;
    resume_remote = 1'b0;
    num_errors    = 0;
    check_count   = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_power_up();
    t_xrst(1'b0);
    t_xrst(1'b1);
    t_modes();
    t_wake();
    t_xrst(1'b0);
    results();
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    results();
  end
endmodule : testbench

`default_nettype wire
